// ---- core/ndc_ctrl.sv ----
// host controller driving a 1M x 1 nibble-mode dram through its strobes
// assumes mclk 10 MHz, dram_q asynchronous to mclk, strobes tied straight to the device
`timescale 1ns/100ps
`include "ndc_defines.svh"

module ndc_ctrl #(
    parameter int PWRUP_CYCLES = `NDC_PWRUP_CYCLES,
    parameter int REF_CYCLES = `NDC_REF_CYCLES
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic req_valid,
    input wire ndc_pkg::ndc_op_type req_op,
    input wire logic [19:0] req_addr,
    input wire logic req_wdata,
    input wire logic ref_row_only,
    output logic req_ready,
    output logic rsp_valid,
    output logic rsp_data,
    output logic init_done,
    output logic dram_ras_n,
    output logic dram_cas_n,
    output logic dram_we_n,
    output logic [`NDC_ADDR_W-1:0] dram_addr,
    output logic dram_d,
    input wire logic dram_q
);

    // ----------------------------------------
    // elaboration checks
    // ----------------------------------------
    if (PWRUP_CYCLES < 1 || PWRUP_CYCLES > 65535) begin : g_pwr_chk
        $error("PWRUP_CYCLES out of range");
    end
    if (REF_CYCLES < 2 || REF_CYCLES > 255) begin : g_ref_chk
        $error("REF_CYCLES out of range");
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    ndc_pkg::ndc_state_type state_reg, state_next;
    ndc_pkg::ndc_op_type op_reg, op_next;
    logic [19:0] addr_reg, addr_next;
    logic wdata_reg, wdata_next;
    logic [15:0] cnt_reg, cnt_next;
    logic [1:0] nib_reg, nib_next;
    logic is_ref_reg, is_ref_next;
    logic ror_reg, ror_next;
    logic [3:0] init_cnt_reg, init_cnt_next;
    logic init_reg, init_next;
    logic [7:0] ref_tmr_reg;
    logic ref_pend_reg, ref_pend_next;
    logic [`NDC_ROW_W-1:0] ref_row_reg, ref_row_next;
    logic ras_reg, ras_next, cas_reg, cas_next, we_reg, we_next, d_reg, d_next;
    logic [`NDC_ADDR_W-1:0] a_reg, a_next;
    logic rsp_v_reg, rsp_v_next, rsp_d_reg, rsp_d_next, ready_reg, ready_next;
    logic q_meta_reg, q_sync_reg;
    logic ref_clr;

    // decode of the latched request and timers
    wire [`NDC_ADDR_W-1:0] row_addr = addr_reg[19:10];
    wire [`NDC_ADDR_W-1:0] col_addr = addr_reg[9:0];
    wire ref_tick = (ref_tmr_reg == 8'(REF_CYCLES - 1));
    wire pwr_done = (cnt_reg == 16'(PWRUP_CYCLES - 1));
    wire sample_now = (cnt_reg == 16'(`NDC_SAMPLE_CYCLES - 1));
    wire nib_more = (op_reg == ndc_pkg::NDC_OP_NIBBLE) && (nib_reg != 2'(`NDC_NIBBLE_BITS - 1));
    wire is_read = (op_reg == ndc_pkg::NDC_OP_READ) || (op_reg == ndc_pkg::NDC_OP_NIBBLE);
    wire take_req = (state_reg == ndc_pkg::ST_IDLE) && ready_reg && req_valid;
    // a tick in the clearing cycle keeps the flag set
    assign ref_pend_next = ref_tick | (ref_pend_reg & ~ref_clr);

    // ----------------------------------------
    // next-state logic
    // ----------------------------------------
    always_comb begin
        state_next = state_reg;
        op_next = op_reg;
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        cnt_next = cnt_reg;
        nib_next = nib_reg;
        is_ref_next = is_ref_reg;
        ror_next = ror_reg;
        init_cnt_next = init_cnt_reg;
        init_next = init_reg;
        ref_row_next = ref_row_reg;
        ras_next = ras_reg;
        cas_next = cas_reg;
        we_next = we_reg;
        d_next = d_reg;
        a_next = a_reg;
        rsp_v_next = 1'b0;
        rsp_d_next = rsp_d_reg;
        ref_clr = 1'b0;
        unique case (state_reg)
            ndc_pkg::ST_PWR: begin
                // strobes stay idle through the whole pause
                cnt_next = cnt_reg + 16'h0001;
                if (pwr_done) begin
                    state_next = ndc_pkg::ST_IDLE;
                end
            end
            ndc_pkg::ST_IDLE: begin
                // refresh first; init only ever uses column before row
                if (!init_reg || ref_pend_reg) begin
                    is_ref_next = 1'b1;
                    ror_next = init_reg && ref_row_only;
                    if (init_reg && ref_row_only) begin
                        a_next = {1'b0, ref_row_reg};
                    end else begin
                        cas_next = 1'b0;
                    end
                    state_next = ndc_pkg::ST_RAS_ON;
                end else if (take_req) begin
                    is_ref_next = 1'b0;
                    op_next = req_op;
                    addr_next = req_addr;
                    wdata_next = req_wdata;
                    nib_next = 2'h0;
                    a_next = req_addr[19:10];
                    state_next = ndc_pkg::ST_RAS_ON;
                end
            end
            ndc_pkg::ST_RAS_ON: begin
                ras_next = 1'b0;
                state_next = is_ref_reg ? ndc_pkg::ST_END : ndc_pkg::ST_COL;
            end
            ndc_pkg::ST_COL: begin
                a_next = col_addr;
                if (op_reg == ndc_pkg::NDC_OP_WRITE) begin
                    we_next = 1'b0;
                    d_next = wdata_reg;
                end
                state_next = ndc_pkg::ST_CAS_ON;
            end
            ndc_pkg::ST_CAS_ON: begin
                cas_next = 1'b0;
                cnt_next = 16'h0000;
                state_next = ndc_pkg::ST_WAIT;
            end
            ndc_pkg::ST_WAIT: begin
                cnt_next = cnt_reg + 16'h0001;
                if (sample_now) begin
                    rsp_v_next = op_reg != ndc_pkg::NDC_OP_WRITE;
                    rsp_d_next = q_sync_reg;
                    if (op_reg == ndc_pkg::NDC_OP_RMW) begin
                        we_next = 1'b0;
                        d_next = wdata_reg;
                        state_next = ndc_pkg::ST_WR_HOLD;
                    end else if (nib_more) begin
                        // row stays low, column strobe toggles
                        cas_next = 1'b1;
                        nib_next = nib_reg + 2'h1;
                        state_next = ndc_pkg::ST_CAS_ON;
                    end else if (is_read && ref_pend_reg) begin
                        // hidden refresh, read bit stays on the pin
                        ras_next = 1'b1;
                        is_ref_next = 1'b1;
                        ror_next = 1'b0;
                        state_next = ndc_pkg::ST_HID_ON;
                    end else begin
                        state_next = ndc_pkg::ST_END;
                    end
                end
            end
            ndc_pkg::ST_WR_HOLD: begin
                state_next = ndc_pkg::ST_END;
            end
            ndc_pkg::ST_HID_ON: begin
                ras_next = 1'b0;
                state_next = ndc_pkg::ST_END;
            end
            ndc_pkg::ST_END: begin
                // close the cycle, count refresh and init work
                ras_next = 1'b1;
                cas_next = 1'b1;
                we_next = 1'b1;
                if (is_ref_reg) begin
                    ref_clr = init_reg;
                    ref_row_next = ref_row_reg + 9'h001;
                    if (!init_reg) begin
                        init_cnt_next = init_cnt_reg + 4'h1;
                        init_next = (init_cnt_reg == 4'(`NDC_INIT_CYCLES - 1));
                    end
                end
                state_next = ndc_pkg::ST_PRE;
            end
            ndc_pkg::ST_PRE: begin
                state_next = ndc_pkg::ST_IDLE;
            end
            default: begin
                state_next = ndc_pkg::ST_IDLE;
            end
        endcase
    end

    // ready only for an idle, refreshed, initialised controller
    assign ready_next = (state_next == ndc_pkg::ST_IDLE) && init_next && !ref_pend_next && !take_req;

    // ----------------------------------------
    // state and pin registers
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state_reg <= ndc_pkg::ST_PWR;
            op_reg <= ndc_pkg::NDC_OP_READ;
            addr_reg <= 20'h00000;
            wdata_reg <= 1'b0;
            cnt_reg <= 16'h0000;
            nib_reg <= 2'h0;
            is_ref_reg <= 1'b0;
            ror_reg <= 1'b0;
            init_cnt_reg <= 4'h0;
            init_reg <= 1'b0;
            ref_row_reg <= 9'h000;
        end else begin
            state_reg <= state_next;
            op_reg <= op_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            cnt_reg <= cnt_next;
            nib_reg <= nib_next;
            is_ref_reg <= is_ref_next;
            ror_reg <= ror_next;
            init_cnt_reg <= init_cnt_next;
            init_reg <= init_next;
            ref_row_reg <= ref_row_next;
        end
    end

    // pins, answer and refresh timer
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ras_reg <= 1'b1;
            cas_reg <= 1'b1;
            we_reg <= 1'b1;
            d_reg <= 1'b0;
            a_reg <= 10'h000;
            rsp_v_reg <= 1'b0;
            rsp_d_reg <= 1'b0;
            ready_reg <= 1'b0;
            ref_tmr_reg <= 8'h00;
            ref_pend_reg <= 1'b0;
        end else begin
            ras_reg <= ras_next;
            cas_reg <= cas_next;
            we_reg <= we_next;
            d_reg <= d_next;
            a_reg <= a_next;
            rsp_v_reg <= rsp_v_next;
            rsp_d_reg <= rsp_d_next;
            ready_reg <= ready_next;
            ref_tmr_reg <= ref_tick ? 8'h00 : ref_tmr_reg + 8'h01;
            ref_pend_reg <= ref_pend_next;
        end
    end

    // two-flop synchroniser on the data pin
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            q_meta_reg <= 1'b0;
            q_sync_reg <= 1'b0;
        end else begin
            q_meta_reg <= dram_q;
            q_sync_reg <= q_meta_reg;
        end
    end

    assign dram_ras_n = ras_reg;
    assign dram_cas_n = cas_reg;
    assign dram_we_n = we_reg;
    assign dram_addr = a_reg;
    assign dram_d = d_reg;
    assign rsp_valid = rsp_v_reg;
    assign rsp_data = rsp_d_reg;
    assign req_ready = ready_reg;
    assign init_done = init_reg;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    sequence s_hid_start;
        state_reg == ndc_pkg::ST_HID_ON;
    endsequence
    sequence s_cas_held_ras_low;
        !dram_cas_n && dram_ras_n ##1 !dram_cas_n && !dram_ras_n;
    endsequence

    a_read_store_high: assert property ($fell(dram_cas_n) && is_read && !is_ref_reg |-> dram_we_n)
        else $error("store strobe low in a read");
    a_early_write_order: assert property ($fell(dram_cas_n) && op_reg == ndc_pkg::NDC_OP_WRITE && !is_ref_reg
        |-> !dram_we_n && dram_d == wdata_reg)
        else $error("early write store strobe late");
    a_rmw_after_read: assert property ($fell(dram_we_n) && op_reg == ndc_pkg::NDC_OP_RMW
        |-> rsp_valid && !dram_cas_n ##1 !dram_we_n && !dram_cas_n)
        else $error("modify write not after read");
    a_ror_cas_high: assert property (!dram_ras_n && is_ref_reg && ror_reg |-> dram_cas_n)
        else $error("column strobe low in row-only refresh");
    a_hidden_cas_hold: assert property (s_hid_start |-> s_cas_held_ras_low)
        else $error("hidden refresh lost column strobe");
    a_cbr_cas_first: assert property ($fell(dram_ras_n) && is_ref_reg && !ror_reg
        && $past(state_reg) == ndc_pkg::ST_RAS_ON
        |-> !dram_cas_n && !$past(dram_cas_n))
        else $error("column strobe not before row strobe");
    a_refresh_served: assert property (init_done && $rose(ref_pend_reg) |-> ##[1:40] !ref_pend_reg)
        else $error("refresh not served in time");
    a_pause_quiet: assert property (state_reg == ndc_pkg::ST_PWR |-> dram_ras_n && dram_cas_n && !req_ready)
        else $error("strobe activity during power-up pause");
    a_init_eight: assert property ($rose(init_done) |-> init_cnt_reg == 4'h8 && $past(is_ref_reg))
        else $error("init done before eight cycles");
    a_nibble_row_low: assert property (state_reg == ndc_pkg::ST_CAS_ON && nib_reg != 2'h0 |-> !dram_ras_n)
        else $error("row strobe rose inside nibble burst");
    a_col_on_pins: assert property ($fell(dram_cas_n) && !is_ref_reg |-> dram_addr == col_addr && !dram_ras_n
        && (nib_reg != 2'h0 || $past(dram_addr, 3) == row_addr))
        else $error("address phases out of order");

endmodule

// ---- inc/ndc_defines.svh ----
// timing counts and widths of the nibble-mode dram controller
// assumes a 10 MHz mclk; included by bare name
`ifndef NDC_DEFINES_SVH
`define NDC_DEFINES_SVH

`define NDC_CLK_NS 100
`define NDC_REF_WINDOW_NS 8000000
`define NDC_REF_ROWS 512
// longest refresh spacing, rounded down
`define NDC_REF_CYCLES (`NDC_REF_WINDOW_NS / `NDC_REF_ROWS / `NDC_CLK_NS)
`define NDC_PWRUP_NS 500000
// least power-up pause, rounded up
`define NDC_PWRUP_CYCLES ((`NDC_PWRUP_NS + `NDC_CLK_NS - 1) / `NDC_CLK_NS)
`define NDC_INIT_CYCLES 8
`define NDC_SAMPLE_CYCLES 3
`define NDC_NIBBLE_BITS 4
`define NDC_ADDR_W 10
`define NDC_ROW_W 9

`endif

// ---- inc/ndc_pkg.sv ----
// types of the nibble-mode dram controller
// assumes nothing beyond a SystemVerilog compiler
package ndc_pkg;

    // ----------------------------------------
    // request kinds
    // ----------------------------------------
    typedef enum logic [1:0] {NDC_OP_READ, NDC_OP_WRITE, NDC_OP_RMW, NDC_OP_NIBBLE} ndc_op_type;

    // ----------------------------------------
    // controller states
    // ----------------------------------------
    typedef enum logic [3:0] {ST_PWR, ST_IDLE, ST_RAS_ON, ST_COL, ST_CAS_ON, ST_WAIT, ST_WR_HOLD, ST_HID_ON,
                              ST_END, ST_PRE} ndc_state_type;

endpackage

// ---- tb/ndc_dram_model.sv ----
// behavioural 1M x 1 nibble dram on the far side of the controller
// assumes strobes come straight from the controller, q read back through the controller's two-flop synchroniser
`timescale 1ns/100ps
module ndc_dram_model #(
    parameter int ACC_NS = 20
) (
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [9:0] addr,
    input wire logic d,
    output logic q,
    output int cbr_cnt,
    output int ror_cnt,
    output int hid_cnt,
    output int early_acc,
    output time t_first
);
    bit mem [int];
    logic [9:0] row_reg, col_reg;
    logic [1:0] nib_reg, idx;
    logic [19:0] cur_reg;
    logic [8:0] rctr_reg;
    logic col_seen, cbr_arm, drv, val;
    initial begin
        {cbr_cnt, ror_cnt, hid_cnt, early_acc, t_first} = '0;
        {col_seen, cbr_arm, drv, val, rctr_reg} = '0;
    end
    // open output shows the inverse of its last bit
    assign q = drv ? val : ~val;
    // row strobe fall: refresh kinds or row latch
    always @(negedge ras_n) begin
        if (t_first == 0) t_first = $time;
        if (!cas_n && cbr_arm) begin
            cbr_cnt++;
            rctr_reg++;
            col_seen = 1;
        end else if (!cas_n) begin
            hid_cnt++;
            col_seen = 1;
        end else begin
            row_reg = addr;
            col_seen = 0;
        end
    end
    always @(posedge ras_n) if (!col_seen) ror_cnt++;
    // column strobe fall: refresh arm, access or nibble step
    always @(negedge cas_n) begin
        if (ras_n) cbr_arm = 1;
        else begin
            if (!col_seen) begin
                col_reg = addr;
                nib_reg = 0;
                col_seen = 1;
            end else nib_reg = nib_reg + 2'h1;
            idx = {row_reg[9], col_reg[9]} + nib_reg;
            cur_reg = {idx[1], row_reg[8:0], idx[0], col_reg[8:0]};
            if (cbr_cnt < 8) early_acc++;
            if (!we_n) mem[cur_reg] = d;
            else begin
                #ACC_NS;
                if (!cas_n) begin
                    val = mem.exists(cur_reg) ? mem[cur_reg] : 1'b0;
                    drv = 1;
                end
            end
        end
    end
    // late store: let the data pin settle first
    always @(negedge we_n) begin
        #1;
        if (!ras_n && !cas_n && drv) mem[cur_reg] = d;
    end
    always @(posedge cas_n) begin
        drv = 0;
        cbr_arm = 0;
    end
endmodule

// ---- tb/nibble_mode_dram_1mx1_test.sv ----
// self-checking bench of the nibble dram controller
// assumes ndc_ctrl, ndc_pkg and the dram model compiled before
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module nibble_mode_dram_1mx1_test;
    localparam int PWR = 20;
    localparam int REF = 60;
    logic mclk, nrst, req_valid, req_wdata, ref_row_only, req_ready, rsp_valid, rsp_data, init_done;
    logic dram_ras_n, dram_cas_n, dram_we_n, dram_d, dram_q, w, e;
    logic [9:0] dram_addr;
    logic [19:0] req_addr, a, lasta;
    logic [31:0] r;
    ndc_pkg::ndc_op_type req_op;
    int cbr_cnt, ror_cnt, hid_cnt, early_acc, fails, checked, seed, n_rsp, exp_rsp, cyc, c0, ref0;
    time t_first, t_rel;
    bit exp_mem [int];
    logic rq [$];
    ndc_ctrl #(.PWRUP_CYCLES(PWR), .REF_CYCLES(REF)) dut_u (.mclk(mclk), .nrst(nrst),
        .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata),
        .ref_row_only(ref_row_only), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .init_done(init_done), .dram_ras_n(dram_ras_n), .dram_cas_n(dram_cas_n), .dram_we_n(dram_we_n),
        .dram_addr(dram_addr), .dram_d(dram_d), .dram_q(dram_q));
    ndc_dram_model model_u (.ras_n(dram_ras_n), .cas_n(dram_cas_n), .we_n(dram_we_n), .addr(dram_addr),
        .d(dram_d), .q(dram_q), .cbr_cnt(cbr_cnt), .ror_cnt(ror_cnt), .hid_cnt(hid_cnt),
        .early_acc(early_acc), .t_first(t_first));
    // ----------------------------------------
    // clock, response monitor, helpers
    // ----------------------------------------
    initial mclk = 1'b0;
    always #50 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (rsp_valid === 1'b1) begin
            rq.push_back(rsp_data);
            n_rsp++;
        end
    end
    function automatic logic mem_of(input logic [19:0] x);
        return exp_mem.exists(int'(x)) ? exp_mem[int'(x)] : 1'b0;
    endfunction
    // device nibble order, wrapping after the fourth bit
    function automatic logic [19:0] nib_a(input logic [19:0] x, input int k);
        logic [1:0] i;
        i = {x[19], x[9]} + k[1:0];
        return {i[1], x[18:10], i[0], x[8:0]};
    endfunction
    task automatic stop_test;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // offer one request and hold it until taken
    task automatic do_req(input ndc_pkg::ndc_op_type op, input logic [19:0] x, input logic wd);
        int n;
        @(posedge mclk);
        #1;
        req_op = op;
        req_addr = x;
        req_wdata = wd;
        req_valid = 1'b1;
        n = 0;
        do begin @(posedge mclk); n++; end while (req_ready !== 1'b1 && n < 3000);
        #1;
        req_valid = 1'b0;
        req_addr = 20'($random(seed));
        `CHK((n < 3000), 1'b1)
        if (op != ndc_pkg::NDC_OP_WRITE) exp_rsp += (op == ndc_pkg::NDC_OP_NIBBLE) ? 4 : 1;
    endtask
    task automatic chk_rd(input logic ex);
        int n;
        logic g;
        n = 0;
        while (rq.size() == 0 && n < 100) begin @(posedge mclk); #1; n++; end
        g = (rq.size() > 0) ? rq.pop_front() : 1'bx;
        `CHK(g, ex)
    endtask
    task automatic do_nib(input logic [19:0] x);
        do_req(ndc_pkg::NDC_OP_NIBBLE, x, 1'b0);
        for (int k = 0; k < 4; k++) chk_rd(mem_of(nib_a(x, k)));
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {fails, checked, cyc, n_rsp, exp_rsp} = '0;
        seed = 75;
        {nrst, req_valid, req_wdata, ref_row_only, req_addr, lasta} = '0;
        req_op = ndc_pkg::NDC_OP_READ;
        repeat (16) @(posedge mclk);
        #1;
        nrst = 1'b1;
        t_rel = $time;
        `CHK({dram_ras_n, dram_cas_n, dram_we_n, req_ready, init_done}, 5'h1C)
        for (int i = 0; i < 3000 && init_done !== 1'b1; i++) @(posedge mclk);
        #1;
        `CHK((cbr_cnt >= 8), 1'b1)
        `CHK((t_first - t_rel >= (PWR - 1) * 100), 1'b1)
        `CHK(early_acc, 0)
        c0 = cbr_cnt + ror_cnt + hid_cnt;
        ref0 = cyc;
        do_req(ndc_pkg::NDC_OP_WRITE, 20'h00000, 1'b1);
        exp_mem[0] = 1'b1;
        do_req(ndc_pkg::NDC_OP_WRITE, 20'hFFFFF, 1'b1);
        exp_mem[20'hFFFFF] = 1'b1;
        do_req(ndc_pkg::NDC_OP_READ, 20'hFFFFF, 1'b0);
        chk_rd(1'b1);
        do_nib(20'hFFFFF);
        for (int it = 0; it < 60; it++) begin
            r = $random(seed);
            a = r[3] ? lasta : 20'($random(seed));
            w = r[4];
            ref_row_only = r[5];
            case (r[1:0])
                2'h0: begin
                    do_req(ndc_pkg::NDC_OP_WRITE, a, w);
                    exp_mem[int'(a)] = w;
                    lasta = a;
                end
                2'h1: begin
                    do_req(ndc_pkg::NDC_OP_READ, a, w);
                    chk_rd(mem_of(a));
                end
                2'h2: begin
                    e = mem_of(a);
                    do_req(ndc_pkg::NDC_OP_RMW, a, w);
                    chk_rd(e);
                    exp_mem[int'(a)] = w;
                    lasta = a;
                end
                default: do_nib(a);
            endcase
        end
        foreach (exp_mem[k]) begin
            do_req(ndc_pkg::NDC_OP_READ, k[19:0], 1'b0);
            chk_rd(exp_mem[k]);
        end
        `CHK(n_rsp, exp_rsp)
        `CHK((ror_cnt > 0), 1'b1)
        `CHK((hid_cnt > 0), 1'b1)
        `CHK((cbr_cnt + ror_cnt + hid_cnt - c0 >= (cyc - ref0) / REF - 1), 1'b1)
        `CHK(early_acc, 0)
        stop_test;
    end
    // watchdog well beyond the expected run length
    initial begin
        #(20000 * 100);
        fails++;
        stop_test;
    end
endmodule
